/* include/sysrst_pkg.sv */
// Purpose: Shared constants and types for the bus reset front end
// Assumes: Bus clock is the single core clock
// Notes:   Reset values and field widths live here only
package sysrst_pkg;
    localparam int          AD_WIDTH       = 32;           // Multiplexed address/data width
    localparam int          CBE_WIDTH      = 4;            // Command/byte-enable width
    localparam int          PM_WIDTH       = 8;            // Power-management context width
    localparam int          VENDOR_WIDTH   = 8;            // Vendor-specific bit width
    localparam int          SYNC_STAGES    = 2;            // Flops on the bus reset pin
    localparam logic [31:0] AD_RESET       = 32'h0000_0000; // Address/data after reset
    localparam logic [3:0]  CBE_RESET      = 4'h0;         // Command/byte enables after reset
    localparam logic [7:0]  PM_RESET       = 8'h00;        // Power context default
    localparam logic [7:0]  VENDOR_RESET   = 8'h00;        // Vendor bits default

    // Bus transaction phase tracker
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_DATA
    } phase_e;
endpackage

/* include/rst_ctrl_if.sv */
// Purpose: Carries synchronised reset state to the front end
// Assumes: Single clock domain
// Notes:   Producer is the reset synchroniser
`timescale 1ns/100ps
interface rst_ctrl_if;
    logic bus_rst_hold;   // Bus reset asserted, clock aligned
    logic func_en;        // Block may operate this cycle

    modport producer (output bus_rst_hold, output func_en);
    modport consumer (input  bus_rst_hold, input  func_en);
endinterface

/* hdl/reset_sync.sv */
// Purpose: Align the bus reset pin to the bus clock
// Assumes: Global reset already synchronous to core_clk
// Notes:   Assertion and release both pass the two flops
`timescale 1ns/100ps
module reset_sync (
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic        bus_reset_pin_n,
    rst_ctrl_if.producer     ctrl
);
    // Whole state of the synchroniser
    typedef struct packed {
        logic [sysrst_pkg::SYNC_STAGES-1:0] stage;  // Active-high reset chain
        logic                               hold;   // Registered bus reset
        logic                               en;     // Registered enable
    } sync_s;

    sync_s state;        // Current state
    sync_s next_state;   // Next state

    // Shift the pin in; only the last stage feeds logic
    always_comb begin
        next_state       = state;
        next_state.stage = {state.stage[sysrst_pkg::SYNC_STAGES-2:0], ~bus_reset_pin_n};
        next_state.hold  = state.stage[sysrst_pkg::SYNC_STAGES-1];   // [RULE11]
        next_state.en    = ~state.stage[sysrst_pkg::SYNC_STAGES-1];
    end

    // Global reset holds bus reset asserted, so both leave together
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state <= '{stage: '1, hold: 1'b1, en: 1'b0};   // [RULE11]
        end else begin
            state <= next_state;
        end
    end

    assign ctrl.bus_rst_hold = state.hold;
    assign ctrl.func_en      = state.en;
endmodule

/* hdl/pci_system_reset_interface.sv */
// Purpose: Reset domains and system-signal front end of a bus host controller
// Assumes: core_clk is the bus clock; reset_n is the global power-on reset
// Notes:   Bus reset keeps power context and vendor bits, clears the rest
// Summary of operation
// (RULE1) Global reset restores every register default
// (RULE2) Nothing operates while global reset held
// (RULE3) Bus reset releases every output driver
// (RULE4) Bus reset spares power context, vendor bits
// (RULE5) Nothing operates while bus reset held
// (RULE6) System gives power-on reset once, bus reset separately
// (RULE7) Sample all bus signals on rising clock
// (RULE8) Address/data carries address, then data phases
// (RULE9) Interrupt pin only pulls low
// (RULE10) Command lines carry command, then byte enables
// (RULE11) Reset release aligned to bus clock
`timescale 1ns/100ps
// Reset domains
// Global reset clears every field, the retained bits included, and
// forces the bus reset chain asserted so both domains let go together.
// Bus reset passes the pin synchroniser first: it takes hold two
// edges after the pin is seen low and lets go two edges after the
// pin is seen high again; function_active rises one edge later.
// While either reset holds, every enable is low, both strobes stay
// quiet and loads from the core are dropped.
// Limitation: a frame that begins before function_active is high
// is not seen; the host bridge must respect the release delay.
//
// Bus side
// Every bus input but the bus reset pin is sampled on the rising clock edge without a
// synchroniser, since the core clock is the bus clock itself.
// Address/data and command lines are driven as whole groups; per-lane
// turnaround and parity belong to logic outside this block.
// The interrupt pin is open drain: its level is tied low and only
// its enable moves, so the pin is never driven high.
//
// Trade-off: a three-edge release delay buys a clean reset edge
// at the price of a slightly later start after either reset.
module pci_system_reset_interface #(
    parameter int AD_W  = sysrst_pkg::AD_WIDTH,
    parameter int CBE_W = sysrst_pkg::CBE_WIDTH,
    parameter int PM_W  = sysrst_pkg::PM_WIDTH,
    parameter int VND_W = sysrst_pkg::VENDOR_WIDTH
) (
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    input  wire logic              bus_reset_n,
    input  wire logic [AD_W-1:0]   addr_data_in,
    output logic      [AD_W-1:0]   addr_data_out,
    output logic      [AD_W-1:0]   addr_data_oe,
    input  wire logic [CBE_W-1:0]  cmd_byte_enable_in,
    output logic      [CBE_W-1:0]  cmd_byte_enable_out,
    output logic      [CBE_W-1:0]  cmd_byte_enable_oe,
    input  wire logic              frame_n,
    input  wire logic              initiator_ready_n,
    input  wire logic              target_ready_n,
    output logic                   host_interrupt_out,
    output logic                   host_interrupt_oe,
    input  wire logic              irq_request,
    input  wire logic              drive_request,
    input  wire logic [AD_W-1:0]   drive_addr_data,
    input  wire logic [CBE_W-1:0]  drive_cmd_byte_enable,
    input  wire logic              pm_context_load,
    input  wire logic [PM_W-1:0]   pm_context_in,
    input  wire logic              vendor_bits_load,
    input  wire logic [VND_W-1:0]  vendor_bits_in,
    output logic      [PM_W-1:0]   pm_context,
    output logic      [VND_W-1:0]  vendor_bits,
    output logic      [AD_W-1:0]   captured_addr,
    output logic      [CBE_W-1:0]  captured_cmd,
    output logic                   addr_strobe,
    output logic      [AD_W-1:0]   captured_data,
    output logic      [CBE_W-1:0]  captured_byte_enable,
    output logic                   data_strobe,
    output logic                   function_active
);
    rst_ctrl_if ctrl ();   // Synchronised reset state

    // Bus reset pin crosses into the clock domain here
    reset_sync u_reset_sync (
        .core_clk        (core_clk),
        .reset_n         (reset_n),
        .bus_reset_pin_n (bus_reset_n),
        .ctrl            (ctrl.producer)
    );

    // Whole state of the front end
    typedef struct packed {
        sysrst_pkg::phase_e phase;      // Transaction phase
        // Pin drive
        logic [AD_W-1:0]    ad_out;     // Address/data drive value
        logic [AD_W-1:0]    ad_oe;      // Address/data enables
        logic [CBE_W-1:0]   cbe_out;    // Command drive value
        logic [CBE_W-1:0]   cbe_oe;     // Command enables
        logic               int_out;    // Interrupt level, always low
        logic               int_oe;     // Interrupt pull-down enable
        // Retained over bus reset
        logic [PM_W-1:0]    pm;         // Power context, kept over bus reset
        logic [VND_W-1:0]   vnd;        // Vendor bits, kept over bus reset
        // Capture results
        logic [AD_W-1:0]    addr;       // Captured address
        logic [CBE_W-1:0]   cmd;        // Captured command
        logic               addr_stb;   // Address phase pulse
        logic [AD_W-1:0]    data;       // Captured data
        logic [CBE_W-1:0]   be;         // Captured byte enables
        logic               data_stb;   // Data phase pulse
        // Status
        logic               active;     // Function enabled
    } front_s;

    front_s state;        // Current state
    front_s next_state;   // Next state

    // Default content of every cleared field
    // Retained bits come in from the caller, so one default
    // serves both the global and the bus reset
    function automatic front_s cleared(input logic [PM_W-1:0] pm_keep,
                                       input logic [VND_W-1:0] vnd_keep);
        front_s c;
        c          = '0;
        c.phase    = sysrst_pkg::PH_IDLE;
        c.ad_out   = AD_W'(sysrst_pkg::AD_RESET);
        c.cbe_out  = CBE_W'(sysrst_pkg::CBE_RESET);
        c.pm       = pm_keep;
        c.vnd      = vnd_keep;
        return c;
    endfunction

    // Phase tracking, pin drive and software-context loads
    always_comb begin
        next_state          = state;
        next_state.addr_stb = 1'b0;
        next_state.data_stb = 1'b0;
        // Active only once the bus reset chain has let go [RULE11]
        next_state.active   = ctrl.func_en;
        // Interrupt: only the pull-down enable moves
        next_state.int_out  = 1'b0;                 // Never driven high [RULE9]
        next_state.int_oe   = irq_request;          // Pull low while pending [RULE9]
        // Drivers follow the core request, a whole lane group at once
        next_state.ad_out   = drive_addr_data;
        next_state.ad_oe    = {AD_W{drive_request}};
        next_state.cbe_out  = drive_cmd_byte_enable;
        next_state.cbe_oe   = {CBE_W{drive_request}};
        // Loads and captures wait for function_active, so the edge on
        // which bus reset lets go cannot take half a frame [RULE5]
        if (state.active) begin
            // Software context, kept later over bus reset
            if (pm_context_load) begin
                next_state.pm = pm_context_in;
            end
            // Vendor bits, same retention as the context
            if (vendor_bits_load) begin
                next_state.vnd = vendor_bits_in;
            end
            // Pins sampled at this rising edge [RULE7]
            unique case (state.phase)
                // Waiting for a transaction
                sysrst_pkg::PH_IDLE: begin
                    // Frame start marks the address phase
                    if (!frame_n) begin
                        next_state.addr     = addr_data_in;        // [RULE8]
                        next_state.cmd      = cmd_byte_enable_in;  // [RULE10]
                        next_state.addr_stb = 1'b1;
                        next_state.phase    = sysrst_pkg::PH_DATA;
                    end
                end
                // Address taken, data phases follow
                sysrst_pkg::PH_DATA: begin
                    // A data phase completes with both ready lines low
                    if (!initiator_ready_n && !target_ready_n) begin
                        next_state.data     = addr_data_in;        // [RULE8]
                        next_state.be       = cmd_byte_enable_in;  // [RULE10]
                        next_state.data_stb = 1'b1;
                        // Frame already high: this was the last phase
                        if (frame_n) begin
                            next_state.phase = sysrst_pkg::PH_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Global reset wins; bus reset keeps only context and vendor bits.
    // A load in the same cycle as bus reset is dropped: the block is off.
    // Bus reset is read from the synchroniser, never from the pin, so
    // a glitch on the pin cannot tear the state apart.
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            // Full default, no function [RULE1] [RULE2]
            state <= cleared(PM_W'(sysrst_pkg::PM_RESET), VND_W'(sysrst_pkg::VENDOR_RESET));
        end else if (ctrl.bus_rst_hold) begin
            // Enables low, retained bits kept [RULE3] [RULE4] [RULE5]
            state <= cleared(state.pm, state.vnd);
        end else begin
            // Normal operation
            state <= next_state;
        end
    end

    // All outputs straight from the state register
    // Pin drive and enables
    assign addr_data_out        = state.ad_out;
    assign addr_data_oe         = state.ad_oe;
    assign cmd_byte_enable_out  = state.cbe_out;
    assign cmd_byte_enable_oe   = state.cbe_oe;
    // Interrupt pull-down
    assign host_interrupt_out   = state.int_out;
    assign host_interrupt_oe    = state.int_oe;
    // Retained over bus reset
    assign pm_context           = state.pm;
    assign vendor_bits          = state.vnd;
    // Capture results and strobes
    assign captured_addr        = state.addr;
    assign captured_cmd         = state.cmd;
    assign addr_strobe          = state.addr_stb;
    assign captured_data        = state.data;
    assign captured_byte_enable = state.be;
    assign data_strobe          = state.data_stb;
    // Out of both resets
    assign function_active      = state.active;
endmodule

/* tb/sysrst_monitor.sv */
// Purpose: Port timing checks for the reset front end
// Assumes: One clock, reset_n synchronous active low
// Notes:   Bound onto every instance of the top module
`timescale 1ns/100ps
module sysrst_monitor (
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic        bus_reset_n,
    input wire logic        irq_request,
    input wire logic        initiator_ready_n,
    input wire logic        target_ready_n,
    input wire logic        host_interrupt_out,
    input wire logic        host_interrupt_oe,
    input wire logic        addr_strobe,
    input wire logic        data_strobe,
    input wire logic        function_active,
    input wire logic [31:0] addr_data_in,
    input wire logic [31:0] addr_data_oe,
    input wire logic [31:0] captured_addr,
    input wire logic [31:0] captured_data,
    input wire logic [3:0]  cmd_byte_enable_in,
    input wire logic [3:0]  cmd_byte_enable_oe,
    input wire logic [3:0]  captured_cmd,
    input wire logic [3:0]  captured_byte_enable,
    input wire logic [7:0]  pm_context,
    input wire logic [7:0]  vendor_bits
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // Data phase completes when both ready lines are low
    sequence data_ready;
        !initiator_ready_n && !target_ready_n && function_active;
    endsequence
    a_global_clear: assert property ($rose(reset_n) |-> !function_active &&
        pm_context == 8'h00 && vendor_bits == 8'h00) else $error("global reset left state");
    a_bus_hiz: assert property (!bus_reset_n [*4] |=> addr_data_oe == 32'h0 &&
        cmd_byte_enable_oe == 4'h0 && !host_interrupt_oe) else $error("driver on in bus reset");
    a_ctx_kept: assert property ((!function_active) [*2] |-> $stable(pm_context) &&
        $stable(vendor_bits)) else $error("retained bits moved while inactive");
    a_idle_quiet: assert property (!function_active |=> !addr_strobe && !data_strobe)
        else $error("capture while inactive");
    a_addr_take: assert property (addr_strobe |->
        captured_addr == $past(addr_data_in) &&
        captured_cmd == $past(cmd_byte_enable_in)) else $error("address capture wrong");
    a_data_take: assert property (data_strobe |-> captured_data == $past(addr_data_in) &&
        captured_byte_enable == $past(cmd_byte_enable_in)) else $error("data capture wrong");
    a_data_follow: assert property (addr_strobe ##0 data_ready |=> data_strobe)
        else $error("data phase missed");
    a_irq_low: assert property ((function_active && irq_request) ##1 function_active |->
        host_interrupt_oe && !host_interrupt_out) else $error("interrupt pin not pulled low");
    a_irq_never_high: assert property (!host_interrupt_out)
        else $error("interrupt pin driven high");
    a_release_sync: assert property ($rose(function_active) |-> $past(reset_n, 3) &&
        $past(bus_reset_n, 3)) else $error("early release");
endmodule
bind pci_system_reset_interface sysrst_monitor u_monitor (.*);

/* tb/host_bridge_model.sv */
// Purpose: Host bridge side of the bus, one transaction per call
// Assumes: Lines change just after a rising edge
// Notes:   Released lines show the inverse of the last value
`timescale 1ns/100ps
module host_bridge_model (
    input  wire logic        core_clk,
    output logic             frame_n,
    output logic             initiator_ready_n,
    output logic             target_ready_n,
    output logic      [31:0] host_ad,
    output logic      [3:0]  host_cbe
);
    initial {frame_n, initiator_ready_n, target_ready_n, host_ad, host_cbe} = '1;
    // Address phase, then one data phase after w target wait cycles
    task automatic cycle(input logic [31:0] a, d, input logic [3:0] c, b, input int w);
        @(posedge core_clk);
        frame_n <= 1'b0; host_ad <= a; host_cbe <= c;
        @(posedge core_clk);
        frame_n <= 1'b1; initiator_ready_n <= 1'b0; host_ad <= d; host_cbe <= b;
        repeat (w) @(posedge core_clk); // Slow target
        target_ready_n <= 1'b0;
        @(posedge core_clk);
        {initiator_ready_n, target_ready_n} <= 2'b11; host_ad <= ~d; host_cbe <= ~b;
    endtask
endmodule

/* tb/tb_top.sv */
// Purpose: Self-checking bench for the reset front end
// Assumes: Seeded random bus traffic plus reset corner cases
// Notes:   Host model drives the bus; bench drives core side
`timescale 1ns/100ps
module tb_top;
    logic core_clk, reset_n, bus_reset_n, frame_n, initiator_ready_n, target_ready_n;
    logic host_interrupt_out, host_interrupt_oe, irq_request, drive_request, addr_strobe;
    logic data_strobe, function_active, pm_context_load, vendor_bits_load;
    logic [31:0] addr_data_in, addr_data_out, addr_data_oe, drive_addr_data, host_ad;
    logic [31:0] captured_addr, captured_data, ra, rd;
    logic [3:0]  cmd_byte_enable_in, cmd_byte_enable_out, cmd_byte_enable_oe, host_cbe;
    logic [3:0]  drive_cmd_byte_enable, captured_cmd, captured_byte_enable, rc, rb;
    logic [7:0]  pm_context_in, vendor_bits_in, pm_context, vendor_bits, ep, ev;
    int          bad_count, samples_checked;
    // Wire level: device wins where it drives, host elsewhere
    assign addr_data_in = (addr_data_oe & addr_data_out) | (~addr_data_oe & host_ad);
    assign cmd_byte_enable_in = (cmd_byte_enable_oe & cmd_byte_enable_out)
                              | (~cmd_byte_enable_oe & host_cbe);
    pci_system_reset_interface u_dut (.*);
    host_bridge_model u_host (.core_clk(core_clk), .frame_n(frame_n), .host_ad(host_ad),
        .initiator_ready_n(initiator_ready_n), .target_ready_n(target_ready_n), .host_cbe(host_cbe));
    function automatic logic [31:0] fill(input logic b);
        return {32{b}};
    endfunction
    task automatic check(input logic [31:0] seen, exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("Checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic settle; // Bounded wait for the block to come up
        for (int i = 0; i < 10 && function_active !== 1'b1; i++) @(posedge core_clk);
        #1;
    endtask
    initial begin
        core_clk = 0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin // Watchdog
        repeat (5000) @(posedge core_clk);
        bad_count++;
        wrap_up();
    end
    initial begin
        {reset_n, irq_request, drive_request, pm_context_load, vendor_bits_load} = '0;
        {drive_addr_data, drive_cmd_byte_enable, pm_context_in, vendor_bits_in} = '0;
        bus_reset_n = 1'b1;
        ra = $urandom(63);
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1; // Power-on reset released; global reset is pulsed again at the end
        settle();
        for (int i = 0; i < 24; i++) begin // Random transfers, slow target on some
            ra = (i == 0) ? 32'hFFFF_FFFF : $urandom;
            rd = (i == 0) ? 32'h0 : $urandom;
            {rc, rb} = 8'($urandom);
            u_host.cycle(ra, rd, rc, rb, i % 3);
            #1;
            check(captured_addr, ra, "addr");
            check({28'h0, captured_cmd}, {28'h0, rc}, "cmd");
            check(captured_data, rd, "data");
            check({28'h0, captured_byte_enable}, {28'h0, rb}, "be");
        end
        ep = 8'($urandom);
        ev = ~ep;
        @(posedge core_clk);
        {drive_request, irq_request, pm_context_load, vendor_bits_load} <= 4'hF;
        drive_addr_data <= $urandom;
        drive_cmd_byte_enable <= 4'($urandom);
        pm_context_in <= ep;
        vendor_bits_in <= ev;
        @(posedge core_clk);
        {pm_context_load, vendor_bits_load} <= 2'b00;
        #1;
        check(addr_data_oe, fill(1'b1), "ad_oe");
        check(addr_data_out, drive_addr_data, "ad_out");
        check({30'h0, host_interrupt_oe, host_interrupt_out}, 32'h2, "irq");
        check({28'h0, cmd_byte_enable_oe}, 32'hF, "cbe_oe");
        check({28'h0, cmd_byte_enable_out}, {28'h0, drive_cmd_byte_enable}, "cbe_out");
        check({16'h0, pm_context, vendor_bits}, {16'h0, ep, ev}, "loaded");
        @(posedge core_clk);
        bus_reset_n <= 1'b0;
        repeat (5) @(posedge core_clk);
        {pm_context_load, vendor_bits_load, pm_context_in} <= {2'b11, ~ep};
        @(posedge core_clk);
        {pm_context_load, vendor_bits_load, bus_reset_n} <= 3'b001;
        #1;
        check(addr_data_oe, fill(1'b0), "ad_oe_rst");
        check({28'h0, cmd_byte_enable_oe}, 32'h0, "cbe_oe_rst");
        check({30'h0, host_interrupt_oe, function_active}, 32'h0, "inactive");
        settle();
        check({16'h0, pm_context, vendor_bits}, {16'h0, ep, ev}, "kept");
        check(captured_addr, 32'h0, "cleared");
        @(posedge core_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        #1;
        check({16'h0, pm_context, vendor_bits}, 32'h0, "global");
        check(addr_data_oe, fill(1'b0), "ad_oe_global");
        check({30'h0, host_interrupt_oe, function_active}, 32'h0, "dead");
        wrap_up();
    end
endmodule
